// >>> inc/tlb_array_if.sv
// Carrier between the flush controller and the entry store.
// Assumes both ends share one clock.
interface tlb_array_if;
  import tlb_pkg::*;
  logic wr_en;
  logic [IDX_W-1:0] wr_idx;
  cam_entry_t wr_cam;
  ram_entry_t wr_ram;
  logic clr_en;
  logic clr_global;
  logic [IDX_W-1:0] clr_idx;
  logic [IDX_W-1:0] rd_idx;
  cam_entry_t rd_cam;
  ram_entry_t rd_ram;
  modport ctrl (output wr_en, wr_idx, wr_cam, wr_ram, clr_en, clr_global, clr_idx, rd_idx,
    input rd_cam, rd_ram);
  modport store (input wr_en, wr_idx, wr_cam, wr_ram, clr_en, clr_global, clr_idx, rd_idx,
    output rd_cam, rd_ram);
endinterface

// >>> inc/tlb_pkg.sv
// Constants and types for the buffer flush and read-back block.
// Assumes a single clock domain and a 32-bit APB register bus.
package tlb_pkg;

  // ==========================================
  // Entry array shape
  localparam int unsigned TLB_ENTRIES = 8;
  localparam int unsigned IDX_W = 3;

  // ==========================================
  // Register byte offsets
  localparam logic [7:0] OFF_PHYS_LOW = 8'h00;
  localparam logic [7:0] OFF_GLOBAL = 8'h04;
  localparam logic [7:0] OFF_SINGLE = 8'h08;
  localparam logic [7:0] OFF_RB_HIGH = 8'h0C;
  localparam logic [7:0] OFF_RB_LOW = 8'h10;
  localparam logic [7:0] OFF_VICTIM = 8'h14;
  localparam logic [7:0] OFF_RD_CMD = 8'h18;
  localparam logic [7:0] OFF_LD_CMD = 8'h1C;
  localparam logic [7:0] OFF_CAM_STAGE = 8'h20;

  // ==========================================
  // Field positions
  localparam int unsigned PTAG_LSB = 10;
  localparam int unsigned PTAG_MSB = 15;
  localparam int unsigned AP_LSB = 8;
  localparam int unsigned AP_MSB = 9;
  localparam int unsigned CMD_BIT = 0;
  localparam int unsigned VTH_MSB = 1;
  localparam int unsigned VTL_LSB = 4;
  localparam int unsigned VTL_MSB = 15;
  localparam int unsigned KEEP_BIT = 3;
  localparam int unsigned VALID_BIT = 2;
  localparam int unsigned SIZE_MSB = 1;
  localparam int unsigned STG_VTH_LSB = 16;
  localparam int unsigned STG_VTH_MSB = 17;

  // ==========================================
  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // Access permission codes
  localparam logic [1:0] AP_NONE0 = 2'h0;
  localparam logic [1:0] AP_NONE1 = 2'h1;
  localparam logic [1:0] AP_READ = 2'h2;
  localparam logic [1:0] AP_FULL = 2'h3;

  // Region size codes
  localparam logic [1:0] SZ_SECTION = 2'h0;
  localparam logic [1:0] SZ_LARGE = 2'h1;
  localparam logic [1:0] SZ_SMALL = 2'h2;
  localparam logic [1:0] SZ_TINY = 2'h3;

  // Virtual-side tag content of one entry
  typedef struct packed {
    logic [1:0] virt_tag_high;
    logic [11:0] virt_tag_low;
    logic keep;
    logic valid;
    logic [1:0] region_size;
  } cam_entry_t;

  // Physical-side low content of one entry
  typedef struct packed {
    logic [5:0] physical_page_tag_low_bits;
    logic [1:0] access_perm;
  } ram_entry_t;

endpackage

// >>> testbench/tlb_flush_readback_bench.sv
// Self-checking bench for the flush and read-back block.
// Assumes the checker file is compiled first; APB driven from here.
module tlb_flush_readback_bench
  import tlb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } row_t;

  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic flush_busy;
  logic stage_read_ok;
  logic stage_write_ok;
  logic rb_is_section;
  logic rb_is_tiny;
  logic [31:0] rd;
  logic er;
  int errors = 0;
  int n_checks = 0;
  int i;
  // Write then read back; read-back words must ignore writes
  row_t rows[6] = '{'{8'h00, 32'hFFFF_FFFF, 32'h0000_FF00}, '{8'h00, 32'h0000_A500, 32'h0000_A500},
    '{8'h0C, 32'h0000_0003, 32'h0000_0000}, '{8'h10, 32'h0000_FFFF, 32'h0000_0000},
    '{8'h14, 32'h0000_0005, 32'h0000_0005}, '{8'h04, 32'h0000_0000, 32'h0000_0000}};

  tlb_flush_readback DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flush_busy(flush_busy), .stage_read_ok(stage_read_ok),
    .stage_write_ok(stage_write_ok), .rb_is_section(rb_is_section), .rb_is_tiny(rb_is_tiny));

  initial forever #20 ref_clk = ~ref_clk;

  // ==========================================
  // Tasks
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Leading edge keeps two transfers from driving psel in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      $display("Error at %0t: ready timeout got %h expected %h", $time, pready, 1'b1);
      summarize();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic poll(input logic [7:0] a);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0000_0000);
      n++;
    end while (rd[0] !== 1'b0 && n < 30);
    if (rd[0] !== 1'b0) begin
      errors++;
      $display("Error at %0t: flush timeout got %h expected %h", $time, rd[0], 1'b0);
      summarize();
    end
  endtask

  function automatic logic [31:0] stage(input int k);
    return {14'h0000, 2'(k) ^ 2'h1, 12'hA50 | 12'(k), k[0], 1'b1, 2'(k)};
  endfunction

  task automatic rb(input int k, input logic keep, input logic vld);
    logic [31:0] s;
    s = stage(k);
    apb(1'b1, OFF_VICTIM, 32'(k));
    apb(1'b1, OFF_RD_CMD, 32'h0000_0001);
    apb(1'b0, OFF_RB_HIGH, 32'h0000_0000);
    chk(rd, {30'h0000_0000, s[17:16]});
    apb(1'b0, OFF_RB_LOW, 32'h0000_0000);
    chk(rd, {16'h0000, s[15:4], keep, vld, s[1:0]});
  endtask

  // ==========================================
  // Sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    foreach (rows[k]) begin
      apb(1'b1, rows[k].a, rows[k].d);
      apb(1'b0, rows[k].a, 32'h0000_0000);
      chk(rd, rows[k].e);
    end
    $display("register rows done");
    for (i = 0; i < 4; i++) begin
      apb(1'b1, OFF_PHYS_LOW, 32'(i) << 8);
      repeat (2) @(posedge ref_clk);
      chk({30'h0000_0000, stage_read_ok, stage_write_ok}, {30'h0000_0000, i[1], i[1] & i[0]});
    end
    $display("permission codes done");
    // Odd entries are kept through a global flush
    // unneeded tag bits zero
    for (i = 0; i < 8; i++) begin
      apb(1'b1, OFF_VICTIM, 32'(i));
      apb(1'b1, OFF_CAM_STAGE, stage(i));
      apb(1'b1, OFF_LD_CMD, 32'h0000_0001);
    end
    apb(1'b1, OFF_GLOBAL, 32'h0000_0001);
    apb(1'b0, OFF_GLOBAL, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    poll(OFF_GLOBAL);
    apb(1'b0, OFF_VICTIM, 32'h0000_0000);
    chk(rd, 32'h0000_0007);
    for (i = 0; i < 8; i++) begin
      rb(i, i[0], i[0]);
    end
    $display("global flush done");
    apb(1'b1, OFF_VICTIM, 32'h0000_0003);
    apb(1'b1, OFF_SINGLE, 32'h0000_0001);
    poll(OFF_SINGLE);
    rb(3, 1'b0, 1'b0);
    rb(1, 1'b1, 1'b1);
    apb(1'b1, 8'h24, 32'hFFFF_FFFF);
    chk({31'h0000_0000, er}, 32'h0000_0001);
    $display("entry flush and unmapped access done");
    // Mid-run reset: status flags and registers must return to zero
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk({27'h000_0000, flush_busy, stage_read_ok, stage_write_ok, rb_is_section, rb_is_tiny}, 32'h0000_0000);
    sys_rst <= 1'b0;
    apb(1'b0, OFF_VICTIM, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, OFF_PHYS_LOW, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, OFF_RB_LOW, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, OFF_GLOBAL, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    $display("mid-run reset done");
    summarize();
  end
endmodule

bind tlb_flush_readback tlb_flush_readback_sva chk_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .flush_busy(flush_busy), .stage_read_ok(stage_read_ok),
  .stage_write_ok(stage_write_ok), .rb_is_section(rb_is_section), .rb_is_tiny(rb_is_tiny));

// >>> testbench/tlb_flush_readback_sva.sv
// Port-level checks for the flush and read-back block.
// Assumes one clock and a bind from the bench top file.
module tlb_flush_readback_sva
  import tlb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic flush_busy,
  input wire logic stage_read_ok,
  input wire logic stage_write_ok,
  input wire logic rb_is_section,
  input wire logic rb_is_tiny
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================
  // Completed transfers
  logic wr_done;
  logic rd_done;
  assign wr_done = psel && penable && pready && pwrite;
  assign rd_done = psel && penable && pready && !pwrite;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // ==========================================
  // Assertions
  chk_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("ready not one cycle after access");
  chk_perm_read: assert property (wr_done && paddr == OFF_PHYS_LOW |->
    ##2 stage_read_ok == $past(pwdata[9], 2)) else $error("read permission flag wrong");
  chk_perm_write: assert property (wr_done && paddr == OFF_PHYS_LOW |->
    ##2 stage_write_ok == ($past(pwdata[9], 2) && $past(pwdata[8], 2))) else $error("full permission flag wrong");
  chk_global_busy: assert property (wr_done && paddr == OFF_GLOBAL && pwdata[0] |->
    ##2 flush_busy [*6] ##[1:8] !flush_busy) else $error("global flush timing wrong");
  chk_single_busy: assert property (wr_done && paddr == OFF_SINGLE && pwdata[0] |->
    ##2 flush_busy ##[1:4] !flush_busy) else $error("entry flush timing wrong");
  chk_rb_section: assert property (rd_done && paddr == OFF_RB_LOW |->
    rb_is_section == (prdata[1:0] == SZ_SECTION)) else $error("section flag wrong");
  chk_rb_tiny: assert property (rd_done && paddr == OFF_RB_LOW |->
    rb_is_tiny == (prdata[1:0] == SZ_TINY)) else $error("tiny flag wrong");
  chk_phys_fields: assert property (rd_done && paddr == OFF_PHYS_LOW |->
    prdata[31:16] == 16'h0000 && prdata[7:0] == 8'h00) else $error("staging word spare bits set");
  chk_rb_high: assert property (rd_done && paddr == OFF_RB_HIGH |->
    prdata[31:2] == 30'h0000_0000) else $error("read-back high spare bits set");

  cov_global: cover property (wr_done && paddr == OFF_GLOBAL && pwdata[0]);
  cov_single: cover property (wr_done && paddr == OFF_SINGLE && pwdata[0]);
  cov_tiny: cover property (rd_done && rb_is_tiny);
endmodule

// >>> verilog/tlb_entry_store.sv
// Flip-flop storage for the buffer entries, with load and clear ports.
// Assumes the controller never loads and clears one entry in one cycle.
module tlb_entry_store
  import tlb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  tlb_array_if.store arr
);

  cam_entry_t cam_q [TLB_ENTRIES];
  ram_entry_t ram_q [TLB_ENTRIES];

  // ==========================================
  // Per-entry storage
  for (genvar i = 0; i < TLB_ENTRIES; i++) begin : g_entry
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        cam_q[i] <= '0;
        ram_q[i] <= '0;
      end else if (arr.clr_en && arr.clr_idx == IDX_W'(i)) begin
        if (arr.clr_global) begin
          if (!cam_q[i].keep) begin
            cam_q[i].valid <= 1'b0;
          end
        end else begin
          cam_q[i].keep <= 1'b0;
          cam_q[i].valid <= 1'b0;
        end
      end else if (arr.wr_en && arr.wr_idx == IDX_W'(i)) begin
        cam_q[i] <= arr.wr_cam;
        ram_q[i] <= arr.wr_ram;
      end
    end
  end

  assign arr.rd_cam = cam_q[arr.rd_idx];
  assign arr.rd_ram = ram_q[arr.rd_idx];

endmodule

// >>> verilog/tlb_flush_readback.sv
// Buffer flush control, physical staging word and tag read-back, as an APB slave.
// Assumes one clock, APB signals from logic on the same clock, no interrupt.
//
// Chosen here: the register offsets and the APB register port.
module tlb_flush_readback
  import tlb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic flush_busy,
  output logic stage_read_ok,
  output logic stage_write_ok,
  output logic rb_is_section,
  output logic rb_is_tiny
);

  typedef enum logic [1:0] {ST_IDLE, ST_GSWEEP, ST_SINGLE} flush_state_t;

  tlb_array_if arr ();

  flush_state_t state_q;
  logic [IDX_W-1:0] sweep_q;
  logic [31:0] phys_low_q;
  logic global_q;
  logic single_q;
  cam_entry_t rb_q;
  logic [IDX_W-1:0] victim_q;
  logic [31:0] stage_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic busy_q;
  logic rd_ok_q;
  logic wr_ok_q;
  logic sec_q;
  logic tiny_q;
  logic acc;
  logic wr_fire;
  logic mapped;
  logic [31:0] rdata_d;

  // ==========================================
  // Decoding helpers
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  function automatic logic perm_reads(input logic [1:0] ap);
    return ap == AP_READ || ap == AP_FULL;
  endfunction

  // ==========================================
  // APB handshake
  // One wait state lets read data come from a flip-flop.
  assign acc = psel && penable;
  assign wr_fire = acc && pready_q && pwrite && !pslverr_q;

  always_comb begin
    mapped = 1'b1;
    rdata_d = RST_WORD;
    case (paddr)
      OFF_PHYS_LOW: begin
        rdata_d = phys_low_q;
      end
      OFF_GLOBAL: begin
        rdata_d[CMD_BIT] = global_q;
      end
      OFF_SINGLE: begin
        rdata_d[CMD_BIT] = single_q;
      end
      OFF_RB_HIGH: begin
        rdata_d[VTH_MSB:0] = rb_q.virt_tag_high;
      end
      OFF_RB_LOW: begin
        rdata_d[VTL_MSB:VTL_LSB] = rb_q.virt_tag_low;
        rdata_d[KEEP_BIT] = rb_q.keep;
        rdata_d[VALID_BIT] = rb_q.valid;
        rdata_d[SIZE_MSB:0] = rb_q.region_size;
      end
      OFF_VICTIM: begin
        rdata_d[IDX_W-1:0] = victim_q;
      end
      OFF_RD_CMD, OFF_LD_CMD: begin
        rdata_d = RST_WORD;
      end
      OFF_CAM_STAGE: begin
        rdata_d = stage_q;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= RST_WORD;
    end else if (acc && !pready_q) begin
      pready_q <= 1'b1;
      pslverr_q <= !mapped;
      prdata_q <= (pwrite || !mapped) ? RST_WORD : rdata_d;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // ==========================================
  // Software-written registers
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phys_low_q <= RST_WORD;
    end else if (wr_fire && hit(paddr, OFF_PHYS_LOW)) begin
      phys_low_q <= RST_WORD;
      phys_low_q[PTAG_MSB:PTAG_LSB] <= pwdata[PTAG_MSB:PTAG_LSB];
      phys_low_q[AP_MSB:AP_LSB] <= pwdata[AP_MSB:AP_LSB];
    end
  end

  // Victim pointer: flushes never move it
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      victim_q <= '0;
    end else if (wr_fire && hit(paddr, OFF_VICTIM)) begin
      victim_q <= pwdata[IDX_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage_q <= RST_WORD;
    end else if (wr_fire && hit(paddr, OFF_CAM_STAGE)) begin
      stage_q <= RST_WORD;
      stage_q[STG_VTH_MSB:STG_VTH_LSB] <= pwdata[STG_VTH_MSB:STG_VTH_LSB];
      stage_q[VTL_MSB:0] <= pwdata[VTL_MSB:0];
    end
  end

  // ==========================================
  // Flush command bits
  // A write of 0 never aborts a running flush.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      global_q <= 1'b0;
    end else if (wr_fire && hit(paddr, OFF_GLOBAL) && pwdata[CMD_BIT]) begin
      global_q <= 1'b1;
    end else if (state_q == ST_GSWEEP && sweep_q == IDX_W'(TLB_ENTRIES - 1)) begin
      global_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      single_q <= 1'b0;
    end else if (wr_fire && hit(paddr, OFF_SINGLE) && pwdata[CMD_BIT]) begin
      single_q <= 1'b1;
    end else if (state_q == ST_SINGLE) begin
      single_q <= 1'b0;
    end
  end

  // ==========================================
  // Flush sequencer
  // Global sweep walks one entry a cycle; it has priority over a single flush.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      sweep_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          sweep_q <= '0;
          // start only on a set bit
          if (global_q) begin
            state_q <= ST_GSWEEP;
          end else if (single_q) begin
            state_q <= ST_SINGLE;
          end
        end
        ST_GSWEEP: begin
          sweep_q <= sweep_q + IDX_W'(1);
          if (sweep_q == IDX_W'(TLB_ENTRIES - 1)) begin
            state_q <= ST_IDLE;
          end
        end
        ST_SINGLE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign arr.clr_en = state_q == ST_GSWEEP || state_q == ST_SINGLE;
  assign arr.clr_global = state_q == ST_GSWEEP;
  assign arr.clr_idx = (state_q == ST_GSWEEP) ? sweep_q : victim_q;

  // ==========================================
  // Entry load and read
  // Loads are dropped while a flush runs, so a sweep never races a load.
  assign arr.wr_en = wr_fire && hit(paddr, OFF_LD_CMD) && pwdata[CMD_BIT] && state_q == ST_IDLE
    && !global_q && !single_q;
  assign arr.wr_idx = victim_q;
  assign arr.wr_cam = '{virt_tag_high: stage_q[STG_VTH_MSB:STG_VTH_LSB],
    virt_tag_low: stage_q[VTL_MSB:VTL_LSB], keep: stage_q[KEEP_BIT],
    valid: stage_q[VALID_BIT], region_size: stage_q[SIZE_MSB:0]};
  assign arr.wr_ram = '{physical_page_tag_low_bits: phys_low_q[PTAG_MSB:PTAG_LSB],
    access_perm: phys_low_q[AP_MSB:AP_LSB]};
  assign arr.rd_idx = victim_q;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rb_q <= '0;
    end else if (wr_fire && hit(paddr, OFF_RD_CMD) && pwdata[CMD_BIT]) begin
      rb_q <= arr.rd_cam;
    end
  end

  tlb_entry_store u_store (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .arr(arr)
  );

  // ==========================================
  // Status outputs
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      rd_ok_q <= 1'b0;
      wr_ok_q <= 1'b0;
      sec_q <= 1'b0;
      tiny_q <= 1'b0;
    end else begin
      busy_q <= global_q || single_q;
      rd_ok_q <= perm_reads(phys_low_q[AP_MSB:AP_LSB]);
      wr_ok_q <= phys_low_q[AP_MSB:AP_LSB] == AP_FULL;
      sec_q <= rb_q.region_size == SZ_SECTION;
      tiny_q <= rb_q.region_size == SZ_TINY;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign flush_busy = busy_q;
  assign stage_read_ok = rd_ok_q;
  assign stage_write_ok = wr_ok_q;
  assign rb_is_section = sec_q;
  assign rb_is_tiny = tiny_q;

endmodule
